// file: hdl/cfs_defs.svh
// Constants for the card file selection block
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH
`define CFS_FID_ROOT    16'h3f00
`define CFS_FID_CUR     16'h3fff
`define CFS_FID_APP     16'h7fff
`define CFS_FIRST_REC   8'h01
`define CFS_FIRST_OFF   16'h0000
`define CFS_MAX_REC     8'hfe
`define CFS_LIN_MAX_LEN 8'hff
`define CFS_CYC_MAX_LEN 8'hfe
`define CFS_SFI_MIN     5'h01
`define CFS_SFI_MAX     5'h1e
`define CFS_NO_SFI      5'h00
`define CFS_SFI_BITS    4:0
`define CFS_ROOT_IDX    0
`define CFS_FID_W       16
`endif

// file: hdl/cfs_pkg.sv
// Types shared by both ends of the file selection link
`default_nettype none
package cfs_pkg;
    typedef enum logic [2:0] {K_DF, K_ADF, K_TRN, K_LIN, K_CYC} cfs_kind_e;
    typedef enum logic [2:0] {
        OP_SEL_FID, OP_PATH_ROOT, OP_PATH_CUR, OP_REC, OP_BIN
    } cfs_op_e;
    typedef enum logic [1:0] {M_ABS, M_NEXT, M_PREV, M_CUR} cfs_mode_e;
    typedef enum logic [2:0] {
        ST_OK, ST_NOT_FOUND, ST_BAD_MODE, ST_RANGE, ST_NO_EF, ST_REFUSED
    } cfs_status_e;
    // Short-code object in the file parameter block: absent, empty, given
    typedef enum logic [1:0] {SF_ABSENT, SF_EMPTY, SF_GIVEN} cfs_sfi_e;
    typedef logic [15:0] cfs_fid_t;
    typedef logic [7:0]  cfs_rec_t;
endpackage
`default_nettype wire

// file: hdl/cfs_link_if.sv
// Command link between terminal end and card end
`default_nettype none
interface cfs_link_if import cfs_pkg::*; ();
    logic        req_valid;
    cfs_op_e     req_op;
    cfs_fid_t    req_fid;
    logic        req_last;
    cfs_mode_e   req_mode;
    cfs_rec_t    req_num;
    logic        req_upd;
    logic [4:0]  req_sfi;
    logic [15:0] req_off;
    logic [7:0]  req_cnt;
    logic        rsp_valid;
    cfs_status_e rsp_status;
    logic [15:0] rsp_len;
    cfs_rec_t    rsp_rlen;
    cfs_rec_t    rsp_rec;
    modport host (output req_valid, req_op, req_fid, req_last, req_mode,
                  req_num, req_upd, req_sfi, req_off, req_cnt,
                  input rsp_valid, rsp_status, rsp_len, rsp_rlen, rsp_rec);
    modport dev (input req_valid, req_op, req_fid, req_last, req_mode,
                 req_num, req_upd, req_sfi, req_off, req_cnt,
                 output rsp_valid, rsp_status, rsp_len, rsp_rlen, rsp_rec);
endinterface
`default_nettype wire

// file: hdl/cfs_recptr.sv
// Record pointer stepping for linear and cyclic files
`include "cfs_defs.svh"
`default_nettype none
module cfs_recptr import cfs_pkg::*; (
    input  wire logic      cyc,
    input  wire logic [7:0] nrec,
    input  wire logic      set,
    input  wire logic [7:0] ptr,
    input  wire cfs_mode_e mode,
    input  wire logic [7:0] num,
    input  wire logic      upd,
    output logic           ok,
    output logic [7:0]     rec
);
    wire       at_last  = set && ptr == nrec;
    wire       at_first = set && ptr == `CFS_FIRST_REC;
    wire [7:0] nxt = (!set || at_last) ? `CFS_FIRST_REC
                                       : 8'(ptr + `CFS_FIRST_REC);
    wire [7:0] prv = (!set || at_first) ? nrec
                                        : 8'(ptr - `CFS_FIRST_REC);
    wire ok_next = !at_last || cyc;
    wire ok_prev = !at_first || cyc;
    wire ok_abs  = num >= `CFS_FIRST_REC && num <= nrec;
    wire cyc_upd = cyc && upd;
    // Cyclic store is taken only in previous mode and lands on the newest slot, number 1
    wire ok_mode = cyc_upd ? mode == M_PREV
                 : mode == M_NEXT ? ok_next
                 : mode == M_PREV ? ok_prev
                 : mode == M_CUR  ? set
                 : ok_abs;
    assign ok  = nrec != 8'h00 && ok_mode;
    assign rec = cyc_upd ? `CFS_FIRST_REC
               : mode == M_NEXT ? nxt
               : mode == M_PREV ? prv
               : mode == M_CUR  ? ptr
               : num;
endmodule
`default_nettype wire

// file: hdl/cfs_dev.sv
// Card end: file table, selection state and record pointer
`include "cfs_defs.svh"
`default_nettype none
module cfs_dev import cfs_pkg::*; #(
    parameter  int NF = 16,
    localparam int IW = $clog2(NF)
) (
    input  wire logic          clk,
    input  wire logic          rst,
    cfs_link_if.dev            lnk,
    input  wire logic          tbl_we,
    input  wire logic [IW-1:0] tbl_idx,
    input  wire cfs_fid_t      tbl_fid,
    input  wire logic [IW-1:0] tbl_par,
    input  wire cfs_kind_e     tbl_kind,
    input  wire cfs_sfi_e      tbl_sfi_mode,
    input  wire logic [4:0]    tbl_sfi,
    input  wire logic [7:0]    tbl_nrec,
    input  wire logic [7:0]    tbl_rlen,
    input  wire logic [15:0]   tbl_size,
    input  wire logic [IW-1:0] act_app,
    output logic               tbl_err,
    output logic [IW-1:0]      cur_dir,
    output logic [IW-1:0]      cur_ef,
    output logic               ef_sel,
    output logic               ptr_set,
    output logic [7:0]         rec_ptr,
    output logic               acc_valid,
    output logic               acc_upd,
    output logic [IW-1:0]      acc_file,
    output logic [7:0]         acc_rec,
    output logic [15:0]        acc_off,
    output logic [7:0]         acc_cnt
);
    typedef enum {S_IDLE, S_PATH, S_FAIL} cfs_st_e;
    localparam logic [IW-1:0] ROOT = IW'(`CFS_ROOT_IDX);

    logic            e_val [NF];
    cfs_fid_t        e_fid [NF];
    logic [IW-1:0]   e_par [NF];
    cfs_kind_e       e_kind[NF];
    logic [4:0]      e_sfi [NF];
    logic [7:0]      e_nrec[NF];
    logic [7:0]      e_rlen[NF];
    logic [7:0]      e_head[NF];
    logic [15:0]     e_size[NF];
    cfs_st_e         st;
    logic [IW-1:0]   walk;
    logic [NF-1:0]   hit_sel, hit_chd, hit_sfi, hit_dup;

    function automatic logic [IW-1:0] first_idx(input logic [NF-1:0] v);
        logic [IW-1:0] r;
        r = ROOT;
        for (int k = NF - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = IW'(k);
            end
        end
        return r;
    endfunction

    function automatic logic is_dir(input cfs_kind_e k);
        return k == K_DF || k == K_ADF;
    endfunction

    // Table load: effective short code and limits
    wire [4:0] new_sfi = tbl_sfi_mode == SF_EMPTY ? `CFS_NO_SFI
                       : tbl_sfi_mode == SF_GIVEN ? tbl_sfi
                       : tbl_fid[`CFS_SFI_BITS];
    wire sfi_rng = new_sfi >= `CFS_SFI_MIN && new_sfi <= `CFS_SFI_MAX;
    wire is_rec_k = tbl_kind == K_LIN || tbl_kind == K_CYC;
    wire bad_lim = is_rec_k && (tbl_nrec > `CFS_MAX_REC
                 || tbl_nrec == 8'h00 || tbl_rlen == 8'h00)
                 || tbl_kind == K_LIN && tbl_rlen > `CFS_LIN_MAX_LEN
                 || tbl_kind == K_CYC && tbl_rlen > `CFS_CYC_MAX_LEN;
    wire bad_sfi = tbl_sfi_mode == SF_GIVEN && !sfi_rng;
    wire load_ok = tbl_we && !bad_lim && !bad_sfi && !(|hit_dup);

    // Request decode
    wire       beat    = lnk.req_valid;
    cfs_op_e   op;
    assign op = lnk.req_op;
    wire       is_path = op == OP_PATH_ROOT || op == OP_PATH_CUR;
    wire       is_data = op == OP_REC || op == OP_BIN;
    wire       first   = st == S_IDLE;
    wire       fid_app = lnk.req_fid == `CFS_FID_APP;
    wire [IW-1:0] base = !first ? walk
                       : op == OP_PATH_ROOT ? ROOT : cur_dir;
    wire bad_start = is_path && (lnk.req_fid == `CFS_FID_CUR
                   || first && op == OP_PATH_ROOT
                      && lnk.req_fid == `CFS_FID_ROOT
                   || first && op == OP_PATH_CUR && fid_app);
    wire app_ok = e_val[act_app] && e_kind[act_app] == K_ADF;
    wire app_jump = first && fid_app && op != OP_PATH_CUR;

    for (genvar i = 0; i < NF; i++) begin : g_ent
        wire fid_eq = e_val[i] && e_fid[i] == lnk.req_fid;
        wire adf_ok = e_kind[i] != K_ADF || IW'(i) == act_app;
        wire near = e_par[i] == cur_dir
                  || is_dir(e_kind[i]) && e_par[i] == e_par[cur_dir]
                  || IW'(i) == e_par[cur_dir] || IW'(i) == cur_dir
                  || IW'(i) == ROOT || ef_sel && IW'(i) == cur_ef;
        assign hit_sel[i] = fid_eq && adf_ok && near;
        assign hit_chd[i] = fid_eq && adf_ok && e_par[i] == base
                          && IW'(i) != ROOT;
        assign hit_sfi[i] = e_val[i] && !is_dir(e_kind[i])
                          && e_par[i] == cur_dir
                          && e_sfi[i] == lnk.req_sfi;
        assign hit_dup[i] = e_val[i] && IW'(i) != tbl_idx
            && (e_fid[i] == tbl_fid
                && (e_par[i] == tbl_par || e_par[i] == e_par[tbl_par])
             || new_sfi != `CFS_NO_SFI && e_sfi[i] == new_sfi
                && e_par[i] == tbl_par);
    end

    // Selection target
    wire [IW-1:0] step_t = app_jump ? act_app : first_idx(hit_chd);
    wire step_ok = !bad_start && (app_jump ? app_ok : |hit_chd);
    wire [IW-1:0] tgt = is_path ? step_t
                      : fid_app ? act_app : first_idx(hit_sel);
    wire tgt_ok = is_path ? st != S_FAIL && step_ok
                : fid_app ? app_ok : |hit_sel;
    wire tgt_dir = is_dir(e_kind[tgt]);
    wire do_sel = beat && !is_data && lnk.req_last && tgt_ok;

    // Data commands, optionally with short code
    wire sfi_use = lnk.req_sfi != `CFS_NO_SFI;
    wire sfi_ok = lnk.req_sfi >= `CFS_SFI_MIN
               && lnk.req_sfi <= `CFS_SFI_MAX && |hit_sfi;
    wire [IW-1:0] f = sfi_use ? first_idx(hit_sfi) : cur_ef;
    wire f_ok = sfi_use ? sfi_ok : ef_sel;
    wire f_cyc = e_kind[f] == K_CYC;
    wire kind_ok = op == OP_REC ? e_kind[f] == K_LIN || f_cyc
                                : e_kind[f] == K_TRN;
    wire rp_set = sfi_use ? 1'b0 : ptr_set;
    wire rp_ok;
    wire [7:0] rp_rec;
    cfs_recptr u_rp (
        .cyc  (f_cyc),
        .nrec (e_nrec[f]),
        .set  (rp_set),
        .ptr  (rec_ptr),
        .mode (lnk.req_mode),
        .num  (lnk.req_num),
        .upd  (lnk.req_upd),
        .ok   (rp_ok),
        .rec  (rp_rec)
    );
    wire [16:0] bin_end = {1'b0, lnk.req_off} + {9'h000, lnk.req_cnt};
    wire bin_ok = bin_end <= {1'b0, e_size[f]}
               && lnk.req_off >= `CFS_FIRST_OFF;
    wire rng_ok = op == OP_REC ? rp_ok : bin_ok;
    wire do_acc = beat && is_data && f_ok && kind_ok && rng_ok;
    wire rot = do_acc && op == OP_REC && f_cyc && lnk.req_upd;

    // Oldest slot becomes newest on a cyclic store
    wire [7:0] head = e_head[f];
    wire [7:0] new_head = head == 8'h00 ? 8'(e_nrec[f] - 8'h01)
                                        : 8'(head - 8'h01);
    wire [7:0] head_eff = rot ? new_head : head;
    wire [8:0] sum = {1'b0, head_eff} + {1'b0, rp_rec} - 9'h001;
    wire [8:0] phys = sum >= {1'b0, e_nrec[f]} ? sum - {1'b0, e_nrec[f]}
                                                : sum;

    cfs_status_e status;
    assign status = is_data ? (!f_ok ? (sfi_use ? ST_NOT_FOUND : ST_NO_EF)
                              : !kind_ok ? ST_BAD_MODE
                              : !rng_ok ? ST_RANGE : ST_OK)
                  : bad_start ? ST_REFUSED
                  : tgt_ok && (lnk.req_last || tgt_dir) ? ST_OK
                  : ST_NOT_FOUND;
    wire rsp_now = beat && (is_data || lnk.req_last
                 || status != ST_OK && first);
    wire [IW-1:0] info = is_data ? f : tgt;
    wire [15:0] rec_size = {8'h00, e_nrec[info]} * {8'h00, e_rlen[info]};

    wire [IW-1:0] next_cur_dir = do_sel ? (tgt_dir ? tgt : e_par[tgt])
                                        : cur_dir;
    wire [IW-1:0] next_cur_ef = do_sel && !tgt_dir ? tgt
                              : do_acc ? f : cur_ef;
    wire next_ef_sel = do_sel ? !tgt_dir : do_acc || ef_sel;
    wire next_ptr_set = do_sel ? 1'b0
                      : do_acc && op == OP_REC ? 1'b1
                      : do_acc && sfi_use ? 1'b0 : ptr_set;
    wire [7:0] next_rec_ptr = do_acc && op == OP_REC ? rp_rec
                                                    : rec_ptr;
    cfs_st_e next_st;
    assign next_st = !beat || is_data || lnk.req_last ? S_IDLE
                   : !is_path ? S_IDLE
                   : st == S_FAIL || !step_ok || !is_dir(e_kind[step_t])
                     ? S_FAIL : S_PATH;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st      <= S_IDLE;
            walk    <= ROOT;
            cur_dir <= ROOT;
            cur_ef  <= ROOT;
            ef_sel  <= 1'b0;
            ptr_set <= 1'b0;
            rec_ptr <= 8'h00;
        end else begin
            st      <= next_st;
            walk    <= beat ? step_t : walk;
            cur_dir <= next_cur_dir;
            cur_ef  <= next_cur_ef;
            ef_sel  <= next_ef_sel;
            ptr_set <= next_ptr_set;
            rec_ptr <= next_rec_ptr;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lnk.rsp_valid  <= 1'b0;
            lnk.rsp_status <= ST_OK;
            lnk.rsp_len    <= 16'h0000;
            lnk.rsp_rlen   <= 8'h00;
            lnk.rsp_rec    <= 8'h00;
            acc_valid      <= 1'b0;
            acc_upd        <= 1'b0;
            acc_file       <= ROOT;
            acc_rec        <= 8'h00;
            acc_off        <= 16'h0000;
            acc_cnt        <= 8'h00;
            tbl_err        <= 1'b0;
        end else begin
            lnk.rsp_valid  <= rsp_now;
            lnk.rsp_status <= status;
            lnk.rsp_len    <= e_kind[info] == K_TRN ? e_size[info]
                                                    : rec_size;
            lnk.rsp_rlen   <= e_rlen[info];
            lnk.rsp_rec    <= do_acc && op == OP_REC ? rp_rec : 8'h00;
            acc_valid      <= do_acc;
            acc_upd        <= lnk.req_upd;
            acc_file       <= f;
            acc_rec        <= 8'(phys + 9'h001);
            acc_off        <= lnk.req_off;
            acc_cnt        <= lnk.req_cnt;
            tbl_err        <= tbl_we && !load_ok;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < NF; k++) begin
                e_val[k] <= 1'b0;
            end
        end else if (load_ok) begin
            e_val[tbl_idx] <= 1'b1;
        end
    end

    // Table payload needs no reset: guarded by e_val
    always_ff @(posedge clk) begin
        if (load_ok) begin
            e_fid[tbl_idx]  <= tbl_fid;
            e_par[tbl_idx]  <= tbl_par;
            e_kind[tbl_idx] <= tbl_kind;
            e_sfi[tbl_idx]  <= sfi_rng ? new_sfi : `CFS_NO_SFI;
            e_nrec[tbl_idx] <= tbl_nrec;
            e_rlen[tbl_idx] <= tbl_rlen;
            e_size[tbl_idx] <= tbl_size;
            e_head[tbl_idx] <= 8'h00;
        end else if (rot) begin
            e_head[f] <= new_head;
        end
    end
endmodule
`default_nettype wire

// file: hdl/cfs_host.sv
// Terminal end: checks requests and sends them as beats
`include "cfs_defs.svh"
`default_nettype none
module cfs_host import cfs_pkg::*; #(
    parameter  int PMAX = 4,
    localparam int PW   = $clog2(PMAX + 1)
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    cfs_link_if.host                  lnk,
    input  wire logic                 u_valid,
    input  wire cfs_op_e              u_op,
    input  wire logic [PMAX*16-1:0]   u_path,
    input  wire logic [PW-1:0]        u_plen,
    input  wire cfs_mode_e            u_mode,
    input  wire logic [7:0]           u_num,
    input  wire logic                 u_upd,
    input  wire logic [4:0]           u_sfi,
    input  wire logic [15:0]          u_off,
    input  wire logic [7:0]           u_cnt,
    output logic                      u_busy,
    output logic                      u_done,
    output cfs_status_e               u_status,
    output logic [15:0]               u_len,
    output logic [7:0]                u_rlen,
    output logic [7:0]                u_rec
);
    typedef enum {H_IDLE, H_SEND, H_WAIT} cfs_hst_e;
    cfs_hst_e            st;
    logic [PMAX*16-1:0]  path;
    logic [PW-1:0]       plen;
    logic [PW-1:0]       idx;
    logic [PMAX-1:0]     has_cur;

    wire is_path = u_op == OP_PATH_ROOT || u_op == OP_PATH_CUR;
    wire [15:0] p0 = u_path[`CFS_FID_W-1:0];
    for (genvar k = 0; k < PMAX; k++) begin : g_el
        assign has_cur[k] = PW'(k) < u_plen
                          && u_path[k*16 +: 16] == `CFS_FID_CUR;
    end
    wire refuse = is_path && (u_plen == '0 || u_plen > PW'(PMAX)
        || u_op == OP_PATH_ROOT && p0 == `CFS_FID_ROOT
        || u_op == OP_PATH_CUR && p0 == `CFS_FID_APP
        || |has_cur);
    wire take = st == H_IDLE && u_valid;
    wire more = is_path && u_plen > PW'(1);
    wire last_next = PW'(idx + PW'(1)) == plen;
    wire [15:0] el = path[idx*16 +: 16];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st   <= H_IDLE;
            path <= '0;
            plen <= '0;
            idx  <= '0;
        end else if (take && !refuse) begin
            st   <= more ? H_SEND : H_WAIT;
            path <= u_path;
            plen <= u_plen;
            idx  <= PW'(1);
        end else if (st == H_SEND) begin
            st  <= last_next ? H_WAIT : H_SEND;
            idx <= PW'(idx + PW'(1));
        end else if (st == H_WAIT && lnk.rsp_valid) begin
            st <= H_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lnk.req_valid <= 1'b0;
            lnk.req_op    <= OP_SEL_FID;
            lnk.req_fid   <= 16'h0000;
            lnk.req_last  <= 1'b0;
            lnk.req_mode  <= M_ABS;
            lnk.req_num   <= 8'h00;
            lnk.req_upd   <= 1'b0;
            lnk.req_sfi   <= `CFS_NO_SFI;
            lnk.req_off   <= 16'h0000;
            lnk.req_cnt   <= 8'h00;
        end else if (take && !refuse) begin
            lnk.req_valid <= 1'b1;
            lnk.req_op    <= u_op;
            lnk.req_fid   <= p0;
            lnk.req_last  <= !more;
            lnk.req_mode  <= u_mode;
            lnk.req_num   <= u_num;
            lnk.req_upd   <= u_upd;
            lnk.req_sfi   <= u_sfi;
            lnk.req_off   <= u_off;
            lnk.req_cnt   <= u_cnt;
        end else if (st == H_SEND) begin
            lnk.req_valid <= 1'b1;
            lnk.req_fid   <= el;
            lnk.req_last  <= last_next;
        end else begin
            lnk.req_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            u_busy   <= 1'b0;
            u_done   <= 1'b0;
            u_status <= ST_OK;
            u_len    <= 16'h0000;
            u_rlen   <= 8'h00;
            u_rec    <= 8'h00;
        end else begin
            u_busy <= take && !refuse || st != H_IDLE
                      && !(st == H_WAIT && lnk.rsp_valid);
            u_done <= take && refuse || st == H_WAIT && lnk.rsp_valid;
            if (take && refuse) begin
                u_status <= ST_REFUSED;
            end else if (st == H_WAIT && lnk.rsp_valid) begin
                u_status <= lnk.rsp_status;
                u_len    <= lnk.rsp_len;
                u_rlen   <= lnk.rsp_rlen;
                u_rec    <= lnk.rsp_rec;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/cfs_link_properties.sv
// Link timing and path checks between the two ends
`default_nettype none
module cfs_link_properties import cfs_pkg::*; (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire cfs_op_e     req_op,
    input wire cfs_fid_t    req_fid,
    input wire logic        req_last,
    input wire logic        rsp_valid,
    input wire cfs_status_e rsp_status,
    input wire cfs_rec_t    rsp_rec
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic pth = req_op == OP_PATH_ROOT || req_op == OP_PATH_CUR;
    sequence s_first;
        req_valid && !$past(req_valid);
    endsequence
    sequence s_mid;
        req_valid && pth && !req_last;
    endsequence
    a_rsp_follows: assert property (
        req_valid && (req_last || !pth) |=> rsp_valid) else $error("late");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("long answer");
    a_rsp_cause: assert property (rsp_valid |-> $past(req_valid))
        else $error("stray answer");
    a_path_beats: assert property (s_mid |=> req_valid && !rsp_valid)
        else $error("path broken");
    a_root_start: assert property (
        s_first ##0 (req_op == OP_PATH_ROOT) |-> req_fid != 16'h3f00)
        else $error("root path start");
    a_cur_start: assert property (
        s_first ##0 (req_op == OP_PATH_CUR) |-> req_fid != 16'h7fff)
        else $error("current path start");
    a_no_cur_id: assert property (
        req_valid && pth |-> req_fid != 16'h3fff) else $error("3fff sent");
    a_rec_numbered: assert property (
        rsp_valid && rsp_status == ST_OK && $past(req_op) == OP_REC
        |-> rsp_rec != 8'h00) else $error("record zero");
endmodule
`default_nettype wire

// file: dv/tb.sv
// Bench joining the terminal end and the card end
`default_nettype none
module tb import cfs_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, tbl_we = 0, u_valid = 0, u_upd = 0;
    logic        tbl_err, u_done, ef_sel;
    logic [3:0]  tbl_idx = 0, tbl_par = 0, cur_dir, cur_ef;
    logic [15:0] tbl_fid = 0, u_off = 0, u_len;
    logic [7:0]  tbl_nrec = 0, tbl_rlen = 0, u_num = 0, u_cnt = 0;
    logic [7:0]  u_rec, rec_ptr, ep, u_rlen, acc_rec, acc_seen;
    logic [15:0] tbl_size = 0;
    logic [4:0]  tbl_sfi = 0;
    logic [3:0]  act_app = 4'h6;
    logic        ptr_set, acc_valid;
    cfs_sfi_e    tbl_sfi_mode = SF_ABSENT;
    logic [63:0] u_path = 0;
    logic [2:0]  u_plen = 0;
    logic [4:0]  u_sfi = 0;
    cfs_kind_e   tbl_kind = K_DF;
    cfs_op_e     u_op = OP_SEL_FID;
    cfs_mode_e   u_mode = M_ABS, m;
    cfs_status_e u_status;
    int          n_fail = 0, compares = 0;
    cfs_link_if  lnk ();
    always #5 clk = ~clk;
    cfs_host i_cfs_host (.*, .u_busy());
    cfs_dev i_cfs_dev (.*, .acc_upd(), .acc_file(), .acc_off(),
        .acc_cnt());
    // Access pulse is gone by u_done, so keep its slot
    always @(posedge clk) if (acc_valid) acc_seen <= acc_rec;
    cfs_link_properties i_props (.clk, .rst, .req_valid(lnk.req_valid),
        .req_op(lnk.req_op), .req_fid(lnk.req_fid), .req_last(lnk.req_last),
        .rsp_valid(lnk.rsp_valid), .rsp_status(lnk.rsp_status),
        .rsp_rec(lnk.rsp_rec));
    task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    function automatic logic [7:0] step(logic [7:0] r, cfs_mode_e d);
        return 8'(d == M_NEXT ? r % 4 + 1 : (r + 2) % 4 + 1);
    endfunction
    // Refusal pulse lands one edge after the load, on the edge that takes tbl_we
    task automatic load(logic [3:0] i, logic [15:0] f, logic [3:0] p,
                        cfs_kind_e k, logic [15:0] nr, logic bad,
                        cfs_sfi_e sm = SF_ABSENT, logic [4:0] sv = 0);
        logic e;
        @(posedge clk);
        {tbl_idx, tbl_fid, tbl_par, tbl_nrec, tbl_rlen} <= {i, f, p, nr};
        tbl_size <= nr;
        tbl_sfi_mode <= sm;
        tbl_sfi <= sv;
        tbl_kind <= k;
        tbl_we <= 1;
        @(posedge clk);
        tbl_we <= 0;
        #1 e = tbl_err;
        @(posedge clk);
        #1 e = e | tbl_err;
        chk("tbl_err", 8'(e), 8'(bad));
    endtask
    task automatic rq(cfs_op_e o, cfs_status_e e, logic [63:0] p = 0,
                      logic [2:0] l = 1, cfs_mode_e d = M_ABS,
                      logic [4:0] s = 0, logic [23:0] oc = 0, logic u = 0,
                      logic [7:0] n = 0);
        @(posedge clk);
        {u_path, u_plen, u_sfi, u_off, u_cnt, u_upd} <= {p, l, s, oc, u};
        u_op <= o;
        u_mode <= d;
        u_num <= n;
        u_valid <= 1;
        @(posedge clk);
        u_valid <= 0;
        // A local refusal answers at the very next edge
        #1;
        for (int i = 0; i < 20 && u_done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("done", 8'(u_done), 8'h01);
        chk("status", 8'(u_status), 8'(e));
    endtask
    initial begin
        void'($urandom(32'hdfc1));
        repeat (4) @(posedge clk);
        rst <= 0;
        #1;
        chk("dir", 8'(cur_dir), 8'h00);
        load(0, 16'h3f00, 0, K_DF, 0, 0);
        load(1, 16'h7f10, 0, K_DF, 0, 0);
        load(2, 16'h6f01, 1, K_LIN, 16'h030a, 0);
        load(3, 16'h6f02, 1, K_CYC, 16'h0406, 0);
        load(4, 16'h2f05, 0, K_TRN, 16'h0064, 0);
        load(5, 16'h7f10, 0, K_DF, 0, 1);
        load(5, 16'h6f09, 1, K_CYC, 16'h04ff, 1);
        load(5, 16'h6f0a, 1, K_LIN, 16'hff04, 1);
        load(6, 16'h7f20, 0, K_ADF, 0, 0);
        load(7, 16'h7f21, 0, K_ADF, 0, 0);
        load(8, 16'h6f03, 1, K_TRN, 16'h0010, 0, SF_GIVEN, 5'h1e);
        load(9, 16'h6f04, 1, K_TRN, 16'h0010, 1, SF_GIVEN, 5'h1f);
        load(9, 16'h6f05, 1, K_TRN, 16'h0010, 0, SF_EMPTY);
        rq(OP_SEL_FID, ST_OK, 64'h7f10);
        rq(OP_SEL_FID, ST_OK, 64'h6f01);
        chk("len", 8'(u_len), 8'h1e);
        chk("rlen", u_rlen, 8'h0a);
        rq(OP_REC, ST_OK, 0, 0, M_PREV);
        chk("rec", u_rec, 8'h03);
        rq(OP_REC, ST_RANGE, 0, 0, M_NEXT);
        chk("ptr", rec_ptr, 8'h03);
        rq(OP_SEL_FID, ST_OK, 64'h6f01);
        rq(OP_REC, ST_OK, 0, 0, M_NEXT);
        chk("rec", u_rec, 8'h01);
        rq(OP_REC, ST_RANGE, 0, 0, M_PREV);
        rq(OP_REC, ST_OK, 0, 0, M_CUR);
        chk("rec", u_rec, 8'h01);
        rq(OP_REC, ST_OK, 0, 0, M_ABS, 0, 0, 0, 8'h02);
        chk("rec", u_rec, 8'h02);
        rq(OP_REC, ST_RANGE, 0, 0, M_ABS, 0, 0, 0, 8'h04);
        chk("ptr", rec_ptr, 8'h02);
        rq(OP_SEL_FID, ST_OK, 64'h6f02);
        rq(OP_REC, ST_RANGE, 0, 0, M_NEXT, 0, 0, 1);
        rq(OP_REC, ST_OK, 0, 0, M_PREV, 0, 0, 1);
        chk("rec", u_rec, 8'h01);
        chk("acc", acc_seen, 8'h04);
        rq(OP_REC, ST_OK, 0, 0, M_PREV, 0, 0, 1);
        chk("rec", u_rec, 8'h01);
        chk("acc", acc_seen, 8'h03);
        ep = 8'h01;
        repeat (10) begin
            m = $urandom_range(0, 1) ? M_NEXT : M_PREV;
            ep = step(ep, m);
            rq(OP_REC, ST_OK, 0, 0, m);
            chk("rec", u_rec, ep);
        end
        rq(OP_REC, ST_OK, 0, 0, M_ABS, 0, 0, 0, 8'h03);
        chk("rec", u_rec, 8'h03);
        rq(OP_SEL_FID, ST_OK, 64'h7f10);
        chk("ef_sel", 8'(ef_sel), 8'h00);
        rq(OP_PATH_CUR, ST_OK, 64'h6f02);
        chk("ef", 8'(cur_ef), 8'h03);
        rq(OP_SEL_FID, ST_OK, 64'h7f10);
        rq(OP_REC, ST_OK, 0, 0, M_NEXT, 5'h01);
        chk("ef", 8'(cur_ef), 8'h02);
        chk("rec", u_rec, 8'h01);
        chk("ptr_set", 8'(ptr_set), 8'h01);
        rq(OP_SEL_FID, ST_NOT_FOUND, 64'h2f05);
        chk("ef", 8'(cur_ef), 8'h02);
        rq(OP_PATH_ROOT, ST_REFUSED, 64'h6f01_7f10_3f00, 3);
        rq(OP_PATH_CUR, ST_REFUSED, 64'h6f01_3fff, 2);
        rq(OP_PATH_ROOT, ST_REFUSED, 0, 0);
        rq(OP_PATH_ROOT, ST_OK, 64'h6f02_7f10, 2);
        chk("ef", 8'(cur_ef), 8'h03);
        rq(OP_BIN, ST_OK, 0, 0, M_ABS, 5'h1e, 24'h000010);
        rq(OP_BIN, ST_NOT_FOUND, 0, 0, M_ABS, 5'h05, 24'h000001);
        rq(OP_SEL_FID, ST_OK, 64'h3f00);
        chk("dir", 8'(cur_dir), 8'h00);
        rq(OP_BIN, ST_OK, 0, 0, M_ABS, 5'h05, 24'h000064);
        rq(OP_BIN, ST_RANGE, 0, 0, M_ABS, 5'h05, 24'h000164);
        rq(OP_SEL_FID, ST_OK, 64'h2f05);
        chk("len", 8'(u_len), 8'h64);
        rq(OP_SEL_FID, ST_NOT_FOUND, 64'h7f21);
        rq(OP_PATH_ROOT, ST_OK, 64'h7fff);
        chk("dir", 8'(cur_dir), 8'h06);
        rq(OP_SEL_FID, ST_OK, 64'h3f00);
        rq(OP_SEL_FID, ST_OK, 64'h7fff);
        chk("dir", 8'(cur_dir), 8'h06);
        @(posedge clk);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        #1;
        chk("dir", 8'(cur_dir), 8'h00);
        chk("ef_sel", 8'(ef_sel), 8'h00);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
